// File: hw/ied_top.sv
// Input event detector: pin terminals and phase condition detector of a counter cell.
`include "ied_map.svh"

module ied_top (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         pin_phase_a,
  input  wire logic                         pin_phase_b,
  input  wire logic [`IED_LATCH_W-1:0]      pin_latch,
  input  wire logic [`IED_EVENT_W-1:0]      pin_event,
  input  wire ied_pkg::ied_width_t          cfg_width,
  input  wire logic                         cfg_mode_wr,
  input  wire ied_pkg::ied_mode_t           cfg_mode,
  input  wire logic                         cfg_bit_wr,
  input  wire logic [`IED_COND_IDX_W-1:0]   cfg_bit_idx,
  input  wire logic                         cfg_bit_val,
  output logic                              phase_term_0,
  output logic                              phase_term_1,
  output logic [`IED_LATCH_W-1:0]           latch_term,
  output logic [`IED_LATCH_W-1:0]           latch_term_present,
  output logic [`IED_EVENT_W-1:0]           event_term,
  output logic [`IED_EVENT_W-1:0]           event_term_present,
  output logic                              detect_out,
  output logic [`IED_COND_W-1:0]            detect_hits,
  output logic [`IED_COND_W-1:0]            cond_enable,
  output ied_pkg::ied_mode_t                pulse_mode
);
  import ied_pkg::*;

  localparam int PIN_W = 2 + `IED_LATCH_W + `IED_EVENT_W;

  logic [PIN_W-1:0]            pin_raw;
  logic [PIN_W-1:0]            pin_sync;
  logic                        in_a;
  logic                        in_b;
  logic [1:0]                  phase_vec;
  logic [1:0]                  phase_rise;
  logic [1:0]                  phase_fall;
  logic                        a_rise;
  logic                        a_fall;
  logic                        b_rise;
  logic                        b_fall;
  logic [`IED_LATCH_W-1:0]     latch_sync;
  logic [`IED_EVENT_W-1:0]     event_sync;
  logic [`IED_LATCH_W-1:0]     next_latch_present;
  logic [`IED_EVENT_W-1:0]     next_event_present;
  logic [`IED_COND_W-1:0]      hit;
  logic [`IED_COND_W-1:0]      next_cond_enable;
  ied_mode_t                   next_pulse_mode;
  logic [`IED_COND_W-1:0]      preset_bits;

  // Every pin is asynchronous to clk, so all of them pass the two-stage synchroniser.
  assign pin_raw = {pin_event, pin_latch, pin_phase_b, pin_phase_a};

  ied_sync #(
    .W (PIN_W)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (pin_raw),
    .q    (pin_sync)
  );

  // Terminal 0 is hard-wired to input A and terminal 1 to input B; no setting reroutes them.
  assign in_a       = pin_sync[0];
  assign in_b       = pin_sync[1];
  assign latch_sync = pin_sync[2 +: `IED_LATCH_W];
  assign event_sync = pin_sync[2 + `IED_LATCH_W +: `IED_EVENT_W];
  assign phase_vec  = {in_b, in_a};

  ied_edge #(
    .W (2)
  ) u_edge (
    .clk  (clk),
    .nrst (nrst),
    .d    (phase_vec),
    .rise (phase_rise),
    .fall (phase_fall)
  );

  assign a_rise = phase_rise[0];
  assign a_fall = phase_fall[0];
  assign b_rise = phase_rise[1];
  assign b_fall = phase_fall[1];

  // Phase terminals show the plain synchronised pin levels.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_term_0 <= 1'b0;
      phase_term_1 <= 1'b0;
    end else begin
      phase_term_0 <= in_a;
      phase_term_1 <= in_b;
    end
  end

  // Which terminals exist depends on the counter width; a missing terminal reads Low.
  always_comb begin
    next_latch_present = '1;
    next_event_present = '1;
    if (cfg_width == ied_width_32) begin
      next_latch_present = {{(`IED_LATCH_W - `IED_LATCH_W_WIDE){1'b0}}, {`IED_LATCH_W_WIDE{1'b1}}};
      next_event_present = {{(`IED_EVENT_W - `IED_EVENT_W_WIDE){1'b0}}, {`IED_EVENT_W_WIDE{1'b1}}};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_term_present <= '0;
      latch_term         <= '0;
    end else begin
      latch_term_present <= next_latch_present;
      latch_term         <= latch_sync & next_latch_present;
    end
  end

  // Event terminals are plain levels so any counter timer input can take them.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_term_present <= '0;
      event_term         <= '0;
    end else begin
      event_term_present <= next_event_present;
      event_term         <= event_sync & next_event_present;
    end
  end

  // Preset patterns for each pulse mode; custom keeps whatever is stored.
  always_comb begin
    case (cfg_mode)
      ied_mode_1ph_x1:             preset_bits = `IED_PRESET_1PH_X1;
      ied_mode_1ph_x2:             preset_bits = `IED_PRESET_1PH_X2;
      ied_mode_up_down_pulse_pair: preset_bits = `IED_PRESET_UPDOWN;
      ied_mode_2ph_x1:             preset_bits = `IED_PRESET_2PH_X1;
      ied_mode_2ph_x2:             preset_bits = `IED_PRESET_2PH_X2;
      ied_mode_2ph_x4:             preset_bits = `IED_PRESET_2PH_X4;
      default:                     preset_bits = cond_enable;
    endcase
  end

  // A single-bit write in the same cycle as a preset lands on top of the preset and still forces custom.
  always_comb begin
    next_cond_enable = cond_enable;
    next_pulse_mode  = pulse_mode;
    if (cfg_mode_wr) begin
      next_cond_enable = preset_bits;
      next_pulse_mode  = cfg_mode;
    end
    if (cfg_bit_wr) begin
      next_cond_enable[cfg_bit_idx] = cfg_bit_val;
      next_pulse_mode               = ied_mode_user;
    end
  end

  // All enables start off and the selector starts at custom.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cond_enable <= `IED_COND_RESET;
      pulse_mode  <= ied_mode_user;
    end else begin
      cond_enable <= next_cond_enable;
      pulse_mode  <= next_pulse_mode;
    end
  end

  // Raw condition hits, independent of the enables.
  always_comb begin
    hit                = '0;
    hit[`IED_C_A_RISE] = a_rise;
    hit[`IED_C_A_FALL] = a_fall;
    hit[`IED_C_A_LOW]  = ~in_a;
    hit[`IED_C_A_HIGH] = in_a;
    hit[`IED_C_B_RISE] = b_rise;
    hit[`IED_C_B_FALL] = b_fall;
    hit[`IED_C_B_LOW]  = ~in_b;
    hit[`IED_C_B_HIGH] = in_b;
    hit[`IED_C_AR_BL]  = a_rise & ~in_b;
    hit[`IED_C_AR_BH]  = a_rise & in_b;
    hit[`IED_C_AF_BL]  = a_fall & ~in_b;
    hit[`IED_C_AF_BH]  = a_fall & in_b;
    hit[`IED_C_AL_BR]  = ~in_a & b_rise;
    hit[`IED_C_AH_BR]  = in_a & b_rise;
    hit[`IED_C_AL_BF]  = ~in_a & b_fall;
    hit[`IED_C_AH_BF]  = in_a & b_fall;
  end

  // Registering the output costs one clock of latency but keeps edge pulses exactly one clock wide.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      detect_hits <= '0;
      detect_out  <= 1'b0;
    end else begin
      detect_hits <= hit & cond_enable;
      detect_out  <= |(hit & cond_enable);
    end
  end

endmodule

// File: hw/ied_map.svh
// Constants of the input event detector: widths, condition bit positions, presets and reset values.
`ifndef IED_MAP_SVH
`define IED_MAP_SVH

`define IED_SYNC_STAGES      2
`define IED_COND_W           16
`define IED_COND_IDX_W       4
`define IED_LATCH_W          2
`define IED_EVENT_W          4
`define IED_LATCH_W_WIDE     1
`define IED_EVENT_W_WIDE     2

`define IED_C_A_RISE         0
`define IED_C_A_FALL         1
`define IED_C_A_LOW          2
`define IED_C_A_HIGH         3
`define IED_C_B_RISE         4
`define IED_C_B_FALL         5
`define IED_C_B_LOW          6
`define IED_C_B_HIGH         7
`define IED_C_AR_BL          8
`define IED_C_AR_BH          9
`define IED_C_AF_BL          10
`define IED_C_AF_BH          11
`define IED_C_AL_BR          12
`define IED_C_AH_BR          13
`define IED_C_AL_BF          14
`define IED_C_AH_BF          15

`define IED_COND_RESET       16'h0000
`define IED_PRESET_1PH_X1    16'h0001
`define IED_PRESET_1PH_X2    16'h0003
`define IED_PRESET_UPDOWN    16'h0011
`define IED_PRESET_2PH_X1    16'h0100
`define IED_PRESET_2PH_X2    16'h0900
`define IED_PRESET_2PH_X4    16'h6900

`endif

// File: hw/ied_pkg.sv
// Types shared by the input event detector modules.
package ied_pkg;

  typedef enum logic [2:0] {
    ied_mode_user,
    ied_mode_1ph_x1,
    ied_mode_1ph_x2,
    ied_mode_up_down_pulse_pair,
    ied_mode_2ph_x1,
    ied_mode_2ph_x2,
    ied_mode_2ph_x4
  } ied_mode_t;

  typedef enum logic {
    ied_width_16,
    ied_width_32
  } ied_width_t;

endpackage

// File: hw/ied_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
module ied_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // Each pin has its own pair; the first stage feeds only the second.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        meta[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end

endmodule

// File: hw/ied_edge.sv
// Edge finder: compares each synchronised level with its value one clock earlier.
module ied_edge #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        prev[i] <= 1'b0;
      end else begin
        prev[i] <= d[i];
      end
    end
    assign rise[i] = d[i] & ~prev[i];
    assign fall[i] = ~d[i] & prev[i];
  end

endmodule

// File: tb/ied_top_properties.sv
// Concurrent checks on the ports of the input event detector.
`include "ied_map.svh"
module ied_top_checker (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic                       pin_phase_a,
  input wire logic [`IED_EVENT_W-1:0]    pin_event,
  input wire ied_pkg::ied_width_t        cfg_width,
  input wire logic                       cfg_mode_wr,
  input wire ied_pkg::ied_mode_t         cfg_mode,
  input wire logic                       cfg_bit_wr,
  input wire logic [`IED_COND_IDX_W-1:0] cfg_bit_idx,
  input wire logic                       cfg_bit_val,
  input wire logic                       phase_term_0,
  input wire logic [`IED_LATCH_W-1:0]    latch_term,
  input wire logic [`IED_LATCH_W-1:0]    latch_term_present,
  input wire logic [`IED_EVENT_W-1:0]    event_term,
  input wire logic [`IED_EVENT_W-1:0]    event_term_present,
  input wire logic                       detect_out,
  input wire logic [`IED_COND_W-1:0]     detect_hits,
  input wire logic [`IED_COND_W-1:0]     cond_enable,
  input wire ied_pkg::ied_mode_t         pulse_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import ied_pkg::*;
  logic [2:0] age;
  // Pin history is only trusted once enough clocks have passed since reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_present16; cfg_width == ied_width_16 |=> latch_term_present == 2'h3 && event_term_present == 4'hf; endproperty
  property p_mask32; cfg_width == ied_width_32 |=> latch_term_present == 2'h1 && event_term[3:2] == 2'h0 && !latch_term[1];
  endproperty
  property p_phase; age > 3'h4 |-> phase_term_0 == $past(pin_phase_a, 3); endproperty
  property p_event; age > 3'h4 |-> event_term[1:0] == $past(pin_event[1:0], 3); endproperty
  property p_preset; cfg_mode_wr && !cfg_bit_wr && cfg_mode == ied_mode_2ph_x4 |=> cond_enable == 16'h6900; endproperty
  property p_user; cfg_bit_wr |=> pulse_mode == ied_mode_user && cond_enable[$past(cfg_bit_idx)] == $past(cfg_bit_val);
  endproperty
  property p_or; detect_out == |detect_hits; endproperty
  property p_rise; age > 3'h4 && detect_hits[0] |-> $past(pin_phase_a, 3) && !$past(pin_phase_a, 4) ##1 !detect_hits[0];
  endproperty
  property p_alow;
    age > 3'h4 && cond_enable == 16'h0004 && $past(cond_enable) == 16'h0004 && $past(cond_enable, 2) == 16'h0004
      |-> detect_out == !$past(pin_phase_a, 3);
  endproperty
  a_present16: assert property (p_present16) else $error("present mask wrong");
  a_mask32: assert property (p_mask32) else $error("wide cell mask wrong");
  a_phase: assert property (p_phase) else $error("phase terminal wrong");
  a_event: assert property (p_event) else $error("event terminal wrong");
  a_preset: assert property (p_preset) else $error("preset not loaded");
  a_user: assert property (p_user) else $error("bit write not applied");
  a_or: assert property (p_or) else $error("output not OR of hits");
  a_rise: assert property (p_rise) else $error("rise pulse wrong");
  a_alow: assert property (p_alow) else $error("low level output wrong");
  c_pulse: cover property (detect_out ##1 !detect_out);
  c_mode: cover property (cfg_mode_wr);
  c_wide: cover property (cfg_width == ied_width_32);
endmodule
bind ied_top ied_top_checker u_chk (.clk, .nrst, .pin_phase_a, .pin_event, .cfg_width, .cfg_mode_wr, .cfg_mode,
  .cfg_bit_wr, .cfg_bit_idx, .cfg_bit_val, .phase_term_0, .latch_term, .latch_term_present, .event_term,
  .event_term_present, .detect_out, .detect_hits, .cond_enable, .pulse_mode);

// File: tb/ied_src.sv
// Pulse source model driving the cell's phase, latch and event pins.
module ied_src (
  input  wire logic       clk,
  input  wire logic [7:0] cmd,
  output logic            pin_a,
  output logic            pin_b,
  output logic [1:0]      pin_lat,
  output logic [3:0]      pin_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins move shortly after an edge, so the cell always sees them as asynchronous.
  initial {pin_evt, pin_lat, pin_b, pin_a} = 8'h00;
  always @(posedge clk) {pin_evt, pin_lat, pin_b, pin_a} <= #1 cmd;
endmodule

// File: tb/tb_input_event_detector.sv
// Self-checking bench for the input event detector.
`include "ied_map.svh"
module tb_input_event_detector import ied_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk = 1'b0;
  logic                      nrst = 1'b0;
  logic [7:0]                cmd = 8'h00;
  ied_width_t                cfg_width = ied_width_16;
  ied_mode_t                 cfg_mode = ied_mode_user;
  ied_mode_t                 pulse_mode;
  logic                      cfg_mode_wr = 1'b0, cfg_bit_wr = 1'b0, cfg_bit_val = 1'b0;
  logic [3:0]                cfg_bit_idx = 4'h0;
  logic                      pin_phase_a, pin_phase_b, phase_term_0, phase_term_1, detect_out;
  logic [1:0]                pin_latch, latch_term, latch_term_present;
  logic [3:0]                pin_event, event_term, event_term_present;
  logic [15:0]               detect_hits, cond_enable;
  int                        miscompares = 0;
  int                        n_tests = 0;
  // Row nibbles: condition index, phases before, phases after ({B,A}), output at 4 and 5 clocks after the phases-after write.
  logic [15:0] rows [19] = '{16'h0012, 16'h1102, 16'h2103, 16'h3233, 16'h4022, 16'h5202, 16'h6203, 16'h7023,
    16'h8012, 16'h9232, 16'ha102, 16'hb322, 16'hc022, 16'hd132, 16'he202, 16'hf312, 16'h8230, 16'h0100, 16'hd020};
  logic [15:0] presets [7] = '{`IED_COND_RESET, `IED_PRESET_1PH_X1, `IED_PRESET_1PH_X2, `IED_PRESET_UPDOWN,
    `IED_PRESET_2PH_X1, `IED_PRESET_2PH_X2, `IED_PRESET_2PH_X4};
  always #2 clk = ~clk;
  ied_src src (.clk(clk), .cmd(cmd), .pin_a(pin_phase_a), .pin_b(pin_phase_b), .pin_lat(pin_latch), .pin_evt(pin_event));
  ied_top dut (.clk, .nrst, .pin_phase_a, .pin_phase_b, .pin_latch, .pin_event, .cfg_width, .cfg_mode_wr, .cfg_mode,
    .cfg_bit_wr, .cfg_bit_idx, .cfg_bit_val, .phase_term_0, .phase_term_1, .latch_term, .latch_term_present,
    .event_term, .event_term_present, .detect_out, .detect_hits, .cond_enable, .pulse_mode);
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input ied_mode_t got, input ied_mode_t exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: mode %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr_bit(input logic [3:0] idx, input logic val);
    cfg_bit_idx = idx;
    cfg_bit_val = val;
    cfg_bit_wr = 1'b1;
    tick(1);
    cfg_bit_wr = 1'b0;
  endtask
  task automatic wr_mode(input ied_mode_t m);
    cfg_mode = m;
    cfg_mode_wr = 1'b1;
    tick(1);
    cfg_mode_wr = 1'b0;
  endtask
  task automatic finish_test;
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    tick(10);
    nrst = 1'b1;
    tick(2);
    foreach (rows[i]) begin
      cmd[1:0] = rows[i][9:8];
      tick(6);
      wr_bit(rows[i][15:12], 1'b1);
      tick(2);
      cmd[1:0] = rows[i][5:4];
      tick(4);
      chk_vec({15'h0, detect_out}, {15'h0, rows[i][1]});
      chk_vec({15'h0, detect_hits[rows[i][15:12]]}, {15'h0, rows[i][1]});
      tick(1);
      chk_vec({15'h0, detect_out}, {15'h0, rows[i][0]});
      wr_bit(rows[i][15:12], 1'b0);
      tick(2);
    end
    for (int m = 1; m < 7; m++) begin
      wr_mode(ied_mode_t'(m));
      chk_vec(cond_enable, presets[m]);
      chk_mode(pulse_mode, ied_mode_t'(m));
      tick(1);
    end
    wr_bit(4'h0, 1'b1);
    chk_vec(cond_enable, 16'h6901);
    chk_mode(pulse_mode, ied_mode_user);
    wr_mode(ied_mode_user);
    chk_vec(cond_enable, 16'h6901);
    chk_mode(pulse_mode, ied_mode_user);
    cfg_mode = ied_mode_1ph_x1;
    cfg_mode_wr = 1'b1;
    wr_bit(4'h4, 1'b1);
    cfg_mode_wr = 1'b0;
    chk_vec(cond_enable, `IED_PRESET_1PH_X1 | 16'h0010);
    chk_mode(pulse_mode, ied_mode_user);
    tick(1);
    nrst = 1'b0;
    tick(1);
    chk_vec(cond_enable, 16'h0000);
    chk_mode(pulse_mode, ied_mode_user);
    nrst = 1'b1;
    cmd = 8'hda;
    tick(6);
    chk_vec({2'h0, phase_term_1, phase_term_0, latch_term, event_term, latch_term_present, event_term_present},
      16'h2b7f);
    cfg_width = ied_width_32;
    tick(2);
    chk_vec({2'h0, phase_term_1, phase_term_0, latch_term, event_term, latch_term_present, event_term_present},
      16'h2053);
    cmd = 8'h25;
    tick(4);
    chk_vec({2'h0, phase_term_1, phase_term_0, latch_term, event_term, latch_term_present, event_term_present},
      16'h1493);
    finish_test;
  end
  // The whole sequence needs under 2000 ns, so this limit only trips on a hang.
  initial begin
    #20000;
    miscompares++;
    finish_test;
  end
endmodule
